// ---- bench/spi_shift_exchange_core_tb.sv ----
// Self-checking bench for the SPI shift exchange core
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module spi_shift_exchange_core_tb;
	import sse_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, timer_tick = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = SSE_HSIZE_WORD;
	logic hreadyout, hresp, sck_out, sck_oe_n, sdo, sdo_oe_n, irq, sck, p_sck, p_ss_n, p_sdo;
	logic [7:0] mdat [2] = '{8'ha5, 8'h5a};
	logic [7:0] pdat [2] = '{8'h3c, 8'hc3};
	int hx [5] = '{2, 8, 32, 6, 8};
	int n_mismatch = 0, samples_checked = 0, tick_cnt = 0;
	assign sck = sck_oe_n ? p_sck : sck_out;
	// Released data line reads inverted so a stale sample shows up
	wire logic sdo_line = sdo_oe_n ? ~sdo : sdo;
	initial forever #12.5 hclk = ~hclk;
	// Timer source: one pulse every six cycles
	always @(posedge hclk) begin
		tick_cnt <= (tick_cnt == 5) ? 0 : tick_cnt + 1;
		timer_tick <= (tick_cnt == 5);
	end
	sse_core dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .serial_clock_pin_in(sck),
		.serial_clock_pin_out(sck_out), .serial_clock_pin_oe_n(sck_oe_n), .serial_out_pin(sdo),
		.serial_out_pin_oe_n(sdo_oe_n), .serial_in_pin(p_sdo), .slave_select_pin_n(p_ss_n),
		.timer_tick(timer_tick), .irq(irq));
	sse_partner p_u (.hclk(hclk), .sck(sck), .peer_sdo(sdo_line), .peer_clk_on(~sck_oe_n),
		.sck_o(p_sck), .ss_n_o(p_ss_n), .sdo_o(p_sdo));
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic hang();
		n_mismatch++;
		$display("MISMATCH wait limit expected %h seen %h", 1'b1, 1'b0);
		final_report();
	endtask
	task automatic wait_rdy();
		int n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) hang();
	endtask
	// Single word transfer; read data lands in rd
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask
	task automatic wait_irq();
		int n = 0;
		while (irq !== 1'b1 && n < 2000) begin
			@(posedge hclk);
			n++;
		end
		if (irq !== 1'b1) hang();
	endtask
	task automatic wait_edge(output int n);
		logic s;
		s = sck_out;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (sck_out === s && n < 100);
		if (n >= 100) hang();
	endtask
	task automatic t_reset();
		logic [7:0] regs [6] = '{SSE_CTRL_OFS, SSE_STAT_OFS, SSE_RELOAD_OFS, SSE_IRQ_STAT_OFS,
			SSE_IRQ_MASK_OFS, 8'h18};
		`CHK("sck_oe_n", 1'b1, sck_oe_n)
		`CHK("sdo_oe_n", 1'b1, sdo_oe_n)
		`CHK("irq", 1'b0, irq)
		bus(8'h18, 1'b1, 32'hff);
		foreach (regs[i]) begin
			bus(regs[i], 1'b0, '0);
			`CHK("reset read", 32'h0, rd)
		end
		bus(SSE_CTRL_OFS, 1'b1, 32'h07);
		repeat (4) @(posedge hclk);
		`CHK("idle sck high", 1'b1, sck_out)
		`CHK("sck driven", 1'b0, sck_oe_n)
		bus(SSE_CTRL_OFS, 1'b1, 32'h0);
	endtask
	task automatic t_master();
		bus(SSE_IRQ_MASK_OFS, 1'b1, 32'h1);
		bus(SSE_CTRL_OFS, 1'b1, 32'h4b);
		for (int b = 0; b < 2; b++) begin
			p_u.sr = pdat[b];
			bus(SSE_DATA_OFS, 1'b1, {24'h00_0000, mdat[b]});
			bus(SSE_DATA_OFS, 1'b1, 32'hff);
			`CHK("collision resp", 1'b0, hresp)
			bus(SSE_STAT_OFS, 1'b0, '0);
			`CHK("busy", 1'b1, rd[1])
			`CHK("sdo driven", 1'b0, sdo_oe_n)
			wait_irq();
			`CHK("sck idle", 1'b0, sck_out)
			`CHK("partner got", mdat[b], p_u.sr)
			bus(SSE_IRQ_STAT_OFS, 1'b0, '0);
			`CHK("done and collision", 32'h3, rd)
			bus(SSE_DATA_OFS, 1'b0, '0);
			`CHK("rx byte", {24'h00_0000, pdat[b]}, rd)
			bus(SSE_STAT_OFS, 1'b0, '0);
			`CHK("full cleared", 1'b0, rd[0])
			bus(SSE_IRQ_STAT_OFS, 1'b1, 32'h3);
			repeat (2) @(posedge hclk);
			`CHK("irq low", 1'b0, irq)
		end
	endtask
	task automatic t_rates();
		int n;
		bus(SSE_RELOAD_OFS, 1'b1, 32'h3);
		for (int i = 0; i < 5; i++) begin
			bus(SSE_CTRL_OFS, 1'b1, (i << 5) | 32'h0b);
			bus(SSE_DATA_OFS, 1'b1, 32'h81);
			repeat (2) wait_edge(n);
			wait_edge(n);
			`CHK("half period", hx[i], n)
			wait_irq();
			bus(SSE_DATA_OFS, 1'b0, '0);
			bus(SSE_IRQ_STAT_OFS, 1'b1, 32'h3);
		end
	endtask
	task automatic t_slave();
		bus(SSE_CTRL_OFS, 1'b1, 32'h19);
		bus(SSE_DATA_OFS, 1'b1, 32'h96);
		p_u.sr = 8'h69;
		fork
			p_u.exchange(8, 8);
			begin
				repeat (20) @(posedge hclk);
				`CHK("slave sdo on", 1'b0, sdo_oe_n)
			end
		join
		repeat (10) @(posedge hclk);
		`CHK("slave sdo off", 1'b1, sdo_oe_n)
		`CHK("master got", 8'h96, p_u.sr)
		bus(SSE_DATA_OFS, 1'b0, '0);
		`CHK("slave rx", 32'h69, rd)
		bus(SSE_IRQ_STAT_OFS, 1'b1, 32'h3);
		p_u.sr = 8'hff;
		p_u.exchange(8, 4);
		repeat (10) @(posedge hclk);
		bus(SSE_IRQ_STAT_OFS, 1'b0, '0);
		`CHK("no done on abort", 32'h0, rd)
		p_u.sr = 8'h0f;
		p_u.exchange(8, 8);
		repeat (10) @(posedge hclk);
		bus(SSE_DATA_OFS, 1'b0, '0);
		`CHK("rx after abort", 32'h0f, rd)
	endtask
	// Master with idle-high clock, change on leading, sample on trailing
	task automatic t_modes();
		bus(SSE_IRQ_STAT_OFS, 1'b1, 32'h3);
		p_u.lead_cap = 1'b0;
		p_u.ckp_m = 1'b1;
		bus(SSE_CTRL_OFS, 1'b1, 32'h47);
		repeat (4) @(posedge hclk);
		`CHK("idle sck high", 1'b1, sck_out)
		p_u.sr = 8'ha3;
		bus(SSE_DATA_OFS, 1'b1, 32'h5c);
		wait_irq();
		`CHK("sck back high", 1'b1, sck_out)
		`CHK("partner got late phase", 8'h5c, p_u.sr)
		bus(SSE_DATA_OFS, 1'b0, '0);
		`CHK("rx late phase", 32'ha3, rd)
		bus(SSE_IRQ_STAT_OFS, 1'b1, 32'h3);
	endtask
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		$display("reset test finished");
		t_master();
		$display("master test finished");
		t_rates();
		$display("rate test finished");
		t_slave();
		$display("slave test finished");
		t_modes();
		$display("mode test finished");
		final_report();
	end
endmodule

// ---- bench/sse_partner.sv ----
// Behavioural SPI partner: remote slave or remote master of the core
`timescale 1ns/1ps
module sse_partner (
	// Clock
	input wire logic hclk,
	// Link seen from the partner
	input wire logic sck,
	input wire logic peer_sdo,
	input wire logic peer_clk_on,
	output logic sck_o,
	output logic ss_n_o,
	output logic sdo_o
);
	logic [7:0] sr;
	logic cap, out_bit, lead_cap, ckp_m;
	// Mode flags are set by the bench before the core is reconfigured
	wire logic lead = sck ^ ckp_m;
	wire logic bit_now = lead_cap ? sr[7] : out_bit;
	initial begin
		sck_o = 1'b0;
		ss_n_o = 1'b1;
		sr = 8'h00;
		cap = 1'b0;
		out_bit = 1'b0;
		lead_cap = 1'b1;
		ckp_m = 1'b0;
	end
	always @(posedge lead) begin
		if (lead_cap) begin
			cap <= peer_sdo;
		end else begin
			out_bit <= sr[7];
		end
	end
	always @(negedge lead) begin
		if (lead_cap) begin
			sr <= {sr[6:0], cap};
		end else begin
			sr <= {sr[6:0], peer_sdo};
		end
	end
	assign sdo_o = (ss_n_o && !peer_clk_on) ? ~bit_now : bit_now;
	task automatic exchange(input int half, input int nbits);
		@(posedge hclk) ss_n_o <= 1'b0;
		repeat (half) @(posedge hclk);
		for (int i = 0; i < nbits; i++) begin
			sck_o <= 1'b1;
			repeat (half) @(posedge hclk);
			sck_o <= 1'b0;
			repeat (half) @(posedge hclk);
		end
		ss_n_o <= 1'b1;
	endtask
endmodule

// ---- design/sse_core.sv ----
// SPI shift exchange core with AHB-Lite register access
`timescale 1ns/1ps
module sse_core (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Serial link pins
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe_n,
	output logic serial_out_pin,
	output logic serial_out_pin_oe_n,
	input wire logic serial_in_pin,
	input wire logic slave_select_pin_n,
	// Timer rate source and interrupt
	input wire logic timer_tick,
	output logic irq
);
	import sse_pkg::*;

	// ****************************************
	// State
	// ****************************************
	sse_ctrl_type ctrl_r;
	sse_state_type st_r, st_nxt;
	sse_pins_type sync1_r, sync2_r, sync3_r, filt_r;
	logic [7:0] reload_r, rx_r, sr_r, wr_addr_r;
	logic [1:0] irq_stat_r, irq_mask_r;
	logic [9:0] tick_cnt_r;
	logic [3:0] edge_cnt_r, bit_cnt_r;
	logic bf_r, wr_pend_r, s_act_d_r, lvl_r, sdo_r, sdo_oe_n_r, sck_r, sck_oe_n_r, irq_r;
	logic [31:0] hrdata_r;
	logic hreadyout_r, hresp_r;

	// ****************************************
	// Bus decode
	// ****************************************
	wire logic acc = hsel & hready & htrans[1] & (hsize == SSE_HSIZE_WORD);
	wire logic wr_ctrl = wr_pend_r & (wr_addr_r == SSE_CTRL_OFS);
	wire logic wr_data = wr_pend_r & (wr_addr_r == SSE_DATA_OFS);
	wire logic wr_reload = wr_pend_r & (wr_addr_r == SSE_RELOAD_OFS);
	wire logic wr_istat = wr_pend_r & (wr_addr_r == SSE_IRQ_STAT_OFS);
	wire logic wr_imask = wr_pend_r & (wr_addr_r == SSE_IRQ_MASK_OFS);
	wire logic rd_data = acc & ~hwrite & (haddr[7:0] == SSE_DATA_OFS);
	wire logic busy = st_r != SSE_ST_IDLE;
	wire logic [7:0] stat_val = {5'h00, sck_r, busy, bf_r};
	wire logic [7:0] rd_mux =
		(haddr[7:0] == SSE_CTRL_OFS) ? ctrl_r :
		(haddr[7:0] == SSE_STAT_OFS) ? stat_val :
		(haddr[7:0] == SSE_DATA_OFS) ? rx_r :
		(haddr[7:0] == SSE_RELOAD_OFS) ? reload_r :
		(haddr[7:0] == SSE_IRQ_STAT_OFS) ? {6'h00, irq_stat_r} :
		(haddr[7:0] == SSE_IRQ_MASK_OFS) ? {6'h00, irq_mask_r} : 8'h00;

	// ****************************************
	// Pin synchroniser
	// ****************************************
	wire sse_pins_type pins_now = sse_pins_type'({serial_in_pin, serial_clock_pin_in, slave_select_pin_n});
	wire logic [2:0] agree = ~(sync2_r ^ sync3_r);
	wire sse_pins_type filt_nxt = sse_pins_type'((agree & sync3_r) | (~agree & filt_r));

	// ****************************************
	// Engine decode
	// ****************************************
	wire logic is_m = ctrl_r.enable & ctrl_r.master;
	wire logic is_s = ctrl_r.enable & ~ctrl_r.master;
	wire logic in_m = st_r == SSE_ST_MASTER;
	wire logic s_sel = ~ctrl_r.ss_en | ~filt_r.ss_n;
	wire logic s_act = filt_r.sck ^ ctrl_r.ckp;
	wire logic [9:0] half_len =
		(ctrl_r.rate == SSE_RATE_DIV4) ? SSE_HALF_DIV4 :
		(ctrl_r.rate == SSE_RATE_DIV16) ? SSE_HALF_DIV16 :
		(ctrl_r.rate == SSE_RATE_RELOAD) ? ({1'b0, reload_r, 1'b0} + SSE_HALF_RELOAD_ADD) : SSE_HALF_DIV64;
	wire logic half_tick = in_m & ((ctrl_r.rate == SSE_RATE_TIMER) ? timer_tick :
		(tick_cnt_r == half_len - 10'h001));
	wire logic m_lead = half_tick & ~edge_cnt_r[0];
	wire logic m_trail = half_tick & edge_cnt_r[0];
	wire logic s_lead = is_s & s_sel & s_act & ~s_act_d_r;
	wire logic s_trail = is_s & s_sel & ~s_act & s_act_d_r;
	wire logic sample_ev = ctrl_r.cke ? (m_lead | s_lead) : (m_trail | s_trail);
	wire logic out_ev = ctrl_r.cke ? (m_trail | s_trail) : (m_lead | s_lead);
	wire logic byte_done = in_m ? (half_tick & (edge_cnt_r == SSE_LAST_EDGE)) :
		(sample_ev & (bit_cnt_r == SSE_LAST_BIT));
	wire logic [7:0] rx_byte = sample_ev ? {sr_r[6:0], filt_r.sdi} : sr_r;
	wire logic ld_ok = wr_data & ~irq_stat_r[SSE_IRQ_WRITE_COLLISION_FLAG] & ~busy;
	wire logic write_collision_flag_ev = wr_data & busy;
	wire logic s_abort = (st_r == SSE_ST_SLAVE) & (~is_s | ~s_sel);
	wire logic [1:0] irq_set = {write_collision_flag_ev, byte_done};
	wire logic [1:0] irq_clr = wr_istat ? hwdata[1:0] : 2'h0;
	// Set wins so an event in the clearing cycle survives
	wire logic [1:0] irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;
	wire logic lvl_nxt = in_m & (half_tick ? ~lvl_r : lvl_r);
	wire logic [3:0] bit_cnt_nxt = (byte_done | s_abort | ld_ok | ~ctrl_r.enable) ? 4'h0 :
		sample_ev ? bit_cnt_r + 4'h1 : bit_cnt_r;

	// ****************************************
	// State machine
	// ****************************************
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			SSE_ST_IDLE: begin
				if (ld_ok & is_m) begin
					st_nxt = SSE_ST_MASTER;
				end else if (is_s & sample_ev) begin
					st_nxt = SSE_ST_SLAVE;
				end
			end
			SSE_ST_MASTER: begin
				if (~is_m | byte_done) begin
					st_nxt = SSE_ST_IDLE;
				end
			end
			SSE_ST_SLAVE: begin
				if (s_abort | byte_done) begin
					st_nxt = SSE_ST_IDLE;
				end
			end
			default: begin
				st_nxt = SSE_ST_IDLE;
			end
		endcase
	end

	// ****************************************
	// Bus slave
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			hrdata_r <= 32'h0000_0000;
			hreadyout_r <= 1'b1;
			hresp_r <= 1'b0;
		end else begin
			wr_pend_r <= acc & hwrite;
			wr_addr_r <= acc ? haddr[7:0] : wr_addr_r;
			hrdata_r <= (acc & ~hwrite) ? {24'h00_0000, rd_mux} : hrdata_r;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r <= SSE_CTRL_RST;
			reload_r <= SSE_RELOAD_RST;
			irq_mask_r <= SSE_IRQ_RST;
			irq_stat_r <= SSE_IRQ_RST;
			irq_r <= 1'b0;
		end else begin
			ctrl_r <= wr_ctrl ? sse_ctrl_type'(hwdata[7:0]) : ctrl_r;
			reload_r <= wr_reload ? hwdata[7:0] : reload_r;
			irq_mask_r <= wr_imask ? hwdata[1:0] : irq_mask_r;
			irq_stat_r <= irq_stat_nxt;
			irq_r <= |(irq_stat_nxt & irq_mask_r);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_r <= 8'h00;
			bf_r <= 1'b0;
		end else begin
			rx_r <= byte_done ? rx_byte : rx_r;
			bf_r <= byte_done | (bf_r & ~rd_data);
		end
	end

	// ****************************************
	// Synchroniser and edge tracking
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync1_r <= SSE_PINS_RST;
			sync2_r <= SSE_PINS_RST;
			sync3_r <= SSE_PINS_RST;
			filt_r <= SSE_PINS_RST;
			s_act_d_r <= 1'b0;
		end else begin
			sync1_r <= pins_now;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			filt_r <= filt_nxt;
			s_act_d_r <= s_act;
		end
	end

	// ****************************************
	// Shift engine
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= SSE_ST_IDLE;
			bit_cnt_r <= 4'h0;
			edge_cnt_r <= 4'h0;
			tick_cnt_r <= 10'h000;
			lvl_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			edge_cnt_r <= in_m ? (edge_cnt_r + {3'h0, half_tick}) : 4'h0;
			tick_cnt_r <= (~in_m | half_tick) ? 10'h000 : tick_cnt_r + 10'h001;
			lvl_r <= lvl_nxt;
		end
	end

	// Reloading the next byte is only legal between bytes
	// eight-bit register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sr_r <= 8'h00;
		end else if (ld_ok) begin
			sr_r <= hwdata[7:0];
		end else if (sample_ev) begin
			sr_r <= {sr_r[6:0], filt_r.sdi};
		end
	end

	// ****************************************
	// Pin drivers
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sdo_r <= 1'b0;
			sdo_oe_n_r <= 1'b1;
			sck_r <= 1'b0;
			sck_oe_n_r <= 1'b1;
		end else begin
			sdo_r <= ld_ok ? hwdata[7] : ((out_ev | ~busy) ? sr_r[7] : sdo_r);
			// drive data out only when master or selected
			sdo_oe_n_r <= ~(is_m | (is_s & s_sel));
			sck_r <= ctrl_r.ckp ^ lvl_nxt;
			sck_oe_n_r <= ~is_m;
		end
	end

	assign hrdata = hrdata_r;
	assign hreadyout = hreadyout_r;
	assign hresp = hresp_r;
	assign serial_clock_pin_out = sck_r;
	assign serial_clock_pin_oe_n = sck_oe_n_r;
	assign serial_out_pin = sdo_r;
	assign serial_out_pin_oe_n = sdo_oe_n_r;
	assign irq = irq_r;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_div4_gap;
		##1 !half_tick ##1 half_tick;
	endsequence

	sequence s_master_start;
		ld_ok && is_m ##1 st_r == SSE_ST_MASTER;
	endsequence

	AST_IDLE_CLOCK: assert property (
		(st_r == SSE_ST_IDLE && $past(st_r) == SSE_ST_IDLE && $stable(ctrl_r.ckp)) |-> sck_r == ctrl_r.ckp)
		else $error("master clock not at idle level");
	AST_WRITE_COLLISION: assert property (
		write_collision_flag_ev |=> irq_stat_r[SSE_IRQ_WRITE_COLLISION_FLAG] && ($past(sample_ev) || sr_r == $past(sr_r)))
		else $error("collision flag not set");
	AST_START_AT_ONCE: assert property (
		s_master_start |-> sr_r == $past(hwdata[7:0]) && sdo_r == sr_r[7])
		else $error("master did not load and start");
	AST_BYTE_COPY: assert property (
		byte_done |=> rx_r == $past(rx_byte) && bf_r && irq_stat_r[SSE_IRQ_DONE])
		else $error("received byte not copied");
	AST_EIGHT_SAMPLES: assert property (
		(byte_done && in_m) |-> bit_cnt_r == (ctrl_r.cke ? 4'h8 : SSE_LAST_BIT))
		else $error("byte did not hold eight samples");
	AST_UNSELECTED_QUIET: assert property (
		(is_s && ctrl_r.ss_en && filt_r.ss_n) [*2] |-> sdo_oe_n_r && st_r != SSE_ST_SLAVE)
		else $error("unselected slave active");
	AST_MSB_FIRST: assert property (
		(sample_ev && !ld_ok) |=> sr_r == {$past(sr_r[6:0]), $past(filt_r.sdi)})
		else $error("shift order wrong");
	AST_EDGE_SPLIT: assert property (
		out_ev |-> !sample_ev)
		else $error("drive and sample on same edge");
	AST_DIV4_RATE: assert property (
		(half_tick && ctrl_r.rate == SSE_RATE_DIV4 && edge_cnt_r != SSE_LAST_EDGE && is_m && !wr_ctrl)
		|-> s_div4_gap)
		else $error("divide by four half period wrong");

endmodule

// ---- design/sse_pkg.sv ----
// Register map, field layout and types of the SPI shift exchange core
package sse_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] SSE_CTRL_OFS = 8'h00;
	localparam logic [7:0] SSE_STAT_OFS = 8'h04;
	localparam logic [7:0] SSE_DATA_OFS = 8'h08;
	localparam logic [7:0] SSE_RELOAD_OFS = 8'h0c;
	localparam logic [7:0] SSE_IRQ_STAT_OFS = 8'h10;
	localparam logic [7:0] SSE_IRQ_MASK_OFS = 8'h14;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int SSE_IRQ_DONE = 0;
	localparam int SSE_IRQ_WRITE_COLLISION_FLAG = 1;
	localparam logic [7:0] SSE_CTRL_RST = 8'h00;
	localparam logic [7:0] SSE_RELOAD_RST = 8'h00;
	localparam logic [1:0] SSE_IRQ_RST = 2'h0;
	localparam logic [2:0] SSE_HSIZE_WORD = 3'h2;

	// ****************************************
	// Clock rate selection and counts
	// ****************************************
	localparam logic [2:0] SSE_RATE_DIV4 = 3'h0;
	localparam logic [2:0] SSE_RATE_DIV16 = 3'h1;
	localparam logic [2:0] SSE_RATE_DIV64 = 3'h2;
	localparam logic [2:0] SSE_RATE_TIMER = 3'h3;
	localparam logic [2:0] SSE_RATE_RELOAD = 3'h4;
	localparam logic [9:0] SSE_HALF_DIV4 = 10'h002;
	localparam logic [9:0] SSE_HALF_DIV16 = 10'h008;
	localparam logic [9:0] SSE_HALF_DIV64 = 10'h020;
	localparam logic [9:0] SSE_HALF_RELOAD_ADD = 10'h002;
	localparam logic [3:0] SSE_LAST_EDGE = 4'hf;
	localparam logic [3:0] SSE_LAST_BIT = 4'h7;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic [2:0] rate;
		logic ss_en;
		logic cke;
		logic ckp;
		logic master;
		logic enable;
	} sse_ctrl_type;

	typedef struct packed {
		logic sdi;
		logic sck;
		logic ss_n;
	} sse_pins_type;

	localparam sse_pins_type SSE_PINS_RST = 3'h1;

	typedef enum logic [1:0] {
		SSE_ST_IDLE,
		SSE_ST_MASTER,
		SSE_ST_SLAVE
	} sse_state_type;

endpackage
